// file: ppfs_pkg.sv
// Constants, register map and state type of the pin function multiplexer.
// Assumes a single 100 MHz clock domain; used by ppfs_top, ppfs_monitor and the testbench.
package ppfs_pkg;
    localparam int NPIN = 15;
    localparam int NXIRQ = 6;
    localparam int NAN = 8;
    localparam int NIRQ = 8;
    localparam int NFN = 65;
    localparam int CLOCK_MHZ = 100;

    // Pins that own a function control register, in register order
    localparam logic [3:0] PIN_P15 = 4'h0, PIN_P16 = 4'h1, PIN_P17 = 4'h2, PIN_P26 = 4'h3, PIN_P27 = 4'h4;
    localparam logic [3:0] PIN_P30 = 4'h5, PIN_P31 = 4'h6, PIN_P32 = 4'h7, PIN_P54 = 4'h8, PIN_P55 = 4'h9;
    localparam logic [3:0] PIN_PA0 = 4'ha, PIN_PA1 = 4'hb, PIN_PA3 = 4'hc, PIN_PA4 = 4'hd, PIN_PA6 = 4'he;

    // Control register fields
    localparam int SEL_LSB = 0;
    localparam int SEL_W = 5;
    localparam int IRQ_SEL_BIT = 6;
    localparam int ANALOG_SEL_BIT = 7;
    localparam logic [4:0] SEL_HIZ = 5'h00;
    localparam logic [7:0] PIN_CTRL_RESET = 8'h00;
    localparam logic [7:0] WMASK_SEL = 8'h1f, WMASK_IRQ = 8'h40, WMASK_ANALOG = 8'h80;

    // Register byte offsets
    localparam logic [31:0] OFS_PIN_BASE = 32'h0000_0000;
    localparam logic [31:0] OFS_IRQ_EXTRA = 32'h0000_0040;
    localparam logic [31:0] OFS_ANALOG4 = 32'h0000_0044;
    localparam logic [31:0] OFS_LIMIT = 32'h0000_0080;

    // Peripheral signal indices; zero means nothing connected
    localparam logic [6:0] FN_NONE = 7'h00;
    localparam logic [6:0] FN_MTU0_B = 7'h01, FN_MTU_CLK_B = 7'h02, FN_T8B2_CLK = 7'h03, FN_UART1_RX = 7'h04;
    localparam logic [6:0] FN_TOUCH_5 = 7'h05, FN_CAN_RX = 7'h06, FN_MTU3_C = 7'h07, FN_MTU3_D = 7'h08;
    localparam logic [6:0] FN_T8B2_OUT = 7'h09, FN_RTC_OUT = 7'h0a, FN_CONV_TRIG = 7'h0b, FN_UART1_TX = 7'h0c;
    localparam logic [6:0] FN_SPI_MOSI = 7'h0d, FN_I2C_SCL = 7'h0e, FN_MTU3_A = 7'h0f, FN_MTU3_B = 7'h10;
    localparam logic [6:0] FN_T8B1_OUT = 7'h11, FN_OUT_DIS_8 = 7'h12, FN_UART1_SCK = 7'h13, FN_SPI_MISO = 7'h14;
    localparam logic [6:0] FN_I2C_SDA = 7'h15, FN_MTU2_A = 7'h16, FN_TOUCH_4 = 7'h17, FN_LPT_OUT = 7'h18;
    localparam logic [6:0] FN_MTU2_B = 7'h19, FN_T8B3_CLK = 7'h1a, FN_TOUCH_3 = 7'h1b, FN_MTU4_B = 7'h1c;
    localparam logic [6:0] FN_T8B3_RST = 7'h1d, FN_TOUCH_2 = 7'h1e, FN_MTU4_D = 7'h1f, FN_UART1_CTS = 7'h20;
    localparam logic [6:0] FN_TOUCH_1 = 7'h21, FN_MTU0_C = 7'h22, FN_T8B3_OUT = 7'h23, FN_UART6_TX = 7'h24;
    localparam logic [6:0] FN_TOUCH_0 = 7'h25, FN_T8B1_CLK = 7'h26, FN_TOUCH_12 = 7'h27, FN_CAN_TX = 7'h28;
    localparam logic [6:0] FN_MTU4_A = 7'h29, FN_TOUCH_11 = 7'h2a, FN_FREQ_REF = 7'h2b, FN_SPI_SSL1 = 7'h2c;
    localparam logic [6:0] FN_TOUCH_32 = 7'h2d, FN_MTU_CLK_C = 7'h2e, FN_UART5_SCK = 7'h2f, FN_SPI_SSL2 = 7'h30;
    localparam logic [6:0] FN_TOUCH_31 = 7'h31, FN_MTU0_D = 7'h32, FN_MTU_CLK_D = 7'h33, FN_MTU5_V = 7'h34;
    localparam logic [6:0] FN_UART5_RX = 7'h35, FN_TOUCH_29 = 7'h36, FN_MTU5_U = 7'h37, FN_MTU_CLK_A = 7'h38;
    localparam logic [6:0] FN_MTU4_C = 7'h39, FN_T8B0_RST = 7'h3a, FN_UART5_TX = 7'h3b, FN_SPI_SSL0 = 7'h3c;
    localparam logic [6:0] FN_TOUCH_28 = 7'h3d, FN_OUT_DIS_2 = 7'h3e, FN_UART5_CTS = 7'h3f, FN_TOUCH_26 = 7'h40;

    typedef struct packed {
        logic [NPIN-1:0][7:0] pin_ctrl;
        logic [NXIRQ-1:0] xirq_sel;
        logic [NAN-1:0] an4_sel;
        logic wr_pend;
        logic [4:0] wr_idx;
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
        logic [NPIN-1:0] mux_sync1;
        logic [NPIN-1:0] mux_sync2;
        logic [NXIRQ-1:0] xirq_sync1;
        logic [NXIRQ-1:0] xirq_sync2;
        logic [NPIN-1:0] pad_out;
        logic [NPIN-1:0] pad_oe;
        logic [NFN-1:0] periph_in;
        logic [NIRQ-1:0] irq;
    } ppfs_state_t;
endpackage : ppfs_pkg

// file: ppfs_top.sv
// Pin function multiplexer with an AHB-Lite register slave.
// Assumes pad inputs are asynchronous; peripheral signals share the bus clock.
//
// The register offsets and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ps

// What this block does
// RULE1 - Five-bit select per pin; code zero leaves the pad floating and unconnected.
// RULE2 - Interrupt select clear blocks the pin from interrupts; set feeds its request line.
// RULE3 - Analog select clear keeps digital use; set connects the pin as analog input; here set only cuts digital routing and interrupts, with no analog output.
// RULE4 - Port1 pin6 codes route clock out, trigger, uart1 tx, spi out, i2c clock.
// RULE5 - Port1 pin7 codes route timer3 pins, timer1 out, disable 8, sck1, spi in, i2c data.
// RULE6 - Port1 pin5 codes route uart1 receive, touch 5 and can receive.
// RULE7 - Port1 pins 2 to 7 drive interrupt requests 2 to 7 when selected.
// RULE8 - Port3 pins 0,1,2,4,6,7 drive requests 0,1,2,4,2,4 when selected.
// RULE9 - Port A pin 3 drives request 6, pin 4 drives request 5.
// RULE10 - Port4 pins 0 to 7 connect to converter channels 0 to 7 when analog.
// RULE11 - Port5 pin4 codes route timer4 compare b, timer1 clock, touch 12, can transmit.
// RULE12 - Port3 pin2 codes route clock out, uart6 transmit and touch 0.
// RULE13 - Port A pin0 codes route timer4 compare a, frequency reference, spi select 1, touch 32.
// RULE14 - Port2 pin6 codes route timer1 out, uart1 transmit, touch 4, low-power timer out.
// RULE15 - Port A pin6 codes route disable 2, uart5 flow control, spi out, touch 26.
// RULE16 - Software writes listed codes only; unlisted codes leave the pad floating.
module ppfs_top (
    input wire logic clock, // 100 MHz clock
    input wire logic rst, // Asynchronous reset, active high
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write when high
    input wire logic [2:0] hsize, // Transfer size, word only
    input wire logic hready, // Bus ready
    input wire logic [31:0] hwdata, // Write data
    output logic [31:0] hrdata, // Read data
    output logic hreadyout, // Slave ready
    output logic hresp, // Always OKAY
    input wire logic [ppfs_pkg::NPIN-1:0] mux_pad_in, // Muxed pad levels
    output logic [ppfs_pkg::NPIN-1:0] mux_pad_out, // Muxed pad drive value
    output logic [ppfs_pkg::NPIN-1:0] mux_pad_oe, // Muxed pad drive enable
    input wire logic [ppfs_pkg::NXIRQ-1:0] xirq_pad_in, // Port1 pins 2..4, port3 pins 4,6,7
    input wire logic [ppfs_pkg::NFN-1:0] periph_out, // Peripheral output values by index
    input wire logic [ppfs_pkg::NFN-1:0] periph_oe, // Peripheral output enables by index
    output logic [ppfs_pkg::NFN-1:0] periph_in, // Pad levels to peripherals by index
    output logic [ppfs_pkg::NIRQ-1:0] irq_req, // External interrupt request lines
    output logic [ppfs_pkg::NAN-1:0] analog_connect // Port4 analog switch to channels 0..7
);

    ppfs_pkg::ppfs_state_t s_q;
    ppfs_pkg::ppfs_state_t s_d;

    localparam logic [4:0] IDX_XIRQ = ppfs_pkg::OFS_IRQ_EXTRA[6:2];
    localparam logic [4:0] IDX_AN4 = ppfs_pkg::OFS_ANALOG4[6:2];

    // Peripheral signal behind a select code; unlisted codes give none
    function automatic logic [6:0] route(input logic [3:0] pin, input logic [4:0] code);
        logic [6:0] f;
        f = ppfs_pkg::FN_NONE;
        case ({pin, code})
            {ppfs_pkg::PIN_P15, 5'h01}: f = ppfs_pkg::FN_MTU0_B;
            {ppfs_pkg::PIN_P15, 5'h02}: f = ppfs_pkg::FN_MTU_CLK_B;
            {ppfs_pkg::PIN_P15, 5'h05}: f = ppfs_pkg::FN_T8B2_CLK;
            {ppfs_pkg::PIN_P15, 5'h0a}: f = ppfs_pkg::FN_UART1_RX;  // see RULE6
            {ppfs_pkg::PIN_P15, 5'h19}: f = ppfs_pkg::FN_TOUCH_5;   // see RULE6
            {ppfs_pkg::PIN_P15, 5'h1c}: f = ppfs_pkg::FN_CAN_RX;    // see RULE6
            {ppfs_pkg::PIN_P16, 5'h01}: f = ppfs_pkg::FN_MTU3_C;
            {ppfs_pkg::PIN_P16, 5'h02}: f = ppfs_pkg::FN_MTU3_D;
            {ppfs_pkg::PIN_P16, 5'h05}: f = ppfs_pkg::FN_T8B2_OUT;
            {ppfs_pkg::PIN_P16, 5'h07}: f = ppfs_pkg::FN_RTC_OUT;   // see RULE4
            {ppfs_pkg::PIN_P16, 5'h09}: f = ppfs_pkg::FN_CONV_TRIG; // see RULE4
            {ppfs_pkg::PIN_P16, 5'h0a}: f = ppfs_pkg::FN_UART1_TX;  // see RULE4
            {ppfs_pkg::PIN_P16, 5'h0d}: f = ppfs_pkg::FN_SPI_MOSI;  // see RULE4
            {ppfs_pkg::PIN_P16, 5'h0f}: f = ppfs_pkg::FN_I2C_SCL;   // see RULE4
            {ppfs_pkg::PIN_P17, 5'h01}: f = ppfs_pkg::FN_MTU3_A;    // see RULE5
            {ppfs_pkg::PIN_P17, 5'h02}: f = ppfs_pkg::FN_MTU3_B;    // see RULE5
            {ppfs_pkg::PIN_P17, 5'h05}: f = ppfs_pkg::FN_T8B1_OUT;  // see RULE5
            {ppfs_pkg::PIN_P17, 5'h07}: f = ppfs_pkg::FN_OUT_DIS_8; // see RULE5
            {ppfs_pkg::PIN_P17, 5'h0a}: f = ppfs_pkg::FN_UART1_SCK; // see RULE5
            {ppfs_pkg::PIN_P17, 5'h0d}: f = ppfs_pkg::FN_SPI_MISO;  // see RULE5
            {ppfs_pkg::PIN_P17, 5'h0f}: f = ppfs_pkg::FN_I2C_SDA;   // see RULE5
            {ppfs_pkg::PIN_P26, 5'h01}: f = ppfs_pkg::FN_MTU2_A;
            {ppfs_pkg::PIN_P26, 5'h05}: f = ppfs_pkg::FN_T8B1_OUT;  // see RULE14
            {ppfs_pkg::PIN_P26, 5'h0a}: f = ppfs_pkg::FN_UART1_TX;  // see RULE14
            {ppfs_pkg::PIN_P26, 5'h19}: f = ppfs_pkg::FN_TOUCH_4;   // see RULE14
            {ppfs_pkg::PIN_P26, 5'h1b}: f = ppfs_pkg::FN_LPT_OUT;   // see RULE14
            {ppfs_pkg::PIN_P27, 5'h01}: f = ppfs_pkg::FN_MTU2_B;
            {ppfs_pkg::PIN_P27, 5'h05}: f = ppfs_pkg::FN_T8B3_CLK;
            {ppfs_pkg::PIN_P27, 5'h0a}: f = ppfs_pkg::FN_UART1_SCK;
            {ppfs_pkg::PIN_P27, 5'h19}: f = ppfs_pkg::FN_TOUCH_3;
            {ppfs_pkg::PIN_P30, 5'h01}: f = ppfs_pkg::FN_MTU4_B;
            {ppfs_pkg::PIN_P30, 5'h05}: f = ppfs_pkg::FN_T8B3_RST;
            {ppfs_pkg::PIN_P30, 5'h07}: f = ppfs_pkg::FN_OUT_DIS_8;
            {ppfs_pkg::PIN_P30, 5'h0a}: f = ppfs_pkg::FN_UART1_RX;
            {ppfs_pkg::PIN_P30, 5'h19}: f = ppfs_pkg::FN_TOUCH_2;
            {ppfs_pkg::PIN_P31, 5'h01}: f = ppfs_pkg::FN_MTU4_D;
            {ppfs_pkg::PIN_P31, 5'h05}: f = ppfs_pkg::FN_T8B2_CLK;
            {ppfs_pkg::PIN_P31, 5'h0b}: f = ppfs_pkg::FN_UART1_CTS;
            {ppfs_pkg::PIN_P31, 5'h19}: f = ppfs_pkg::FN_TOUCH_1;
            {ppfs_pkg::PIN_P32, 5'h01}: f = ppfs_pkg::FN_MTU0_C;
            {ppfs_pkg::PIN_P32, 5'h05}: f = ppfs_pkg::FN_T8B3_OUT;
            {ppfs_pkg::PIN_P32, 5'h07}: f = ppfs_pkg::FN_RTC_OUT;   // see RULE12
            {ppfs_pkg::PIN_P32, 5'h0b}: f = ppfs_pkg::FN_UART6_TX;  // see RULE12
            {ppfs_pkg::PIN_P32, 5'h19}: f = ppfs_pkg::FN_TOUCH_0;   // see RULE12
            {ppfs_pkg::PIN_P54, 5'h01}: f = ppfs_pkg::FN_MTU4_B;    // see RULE11
            {ppfs_pkg::PIN_P54, 5'h05}: f = ppfs_pkg::FN_T8B1_CLK;  // see RULE11
            {ppfs_pkg::PIN_P54, 5'h19}: f = ppfs_pkg::FN_TOUCH_12;  // see RULE11
            {ppfs_pkg::PIN_P54, 5'h1c}: f = ppfs_pkg::FN_CAN_TX;    // see RULE11
            {ppfs_pkg::PIN_P55, 5'h01}: f = ppfs_pkg::FN_MTU4_D;
            {ppfs_pkg::PIN_P55, 5'h02}: f = ppfs_pkg::FN_MTU4_A;
            {ppfs_pkg::PIN_P55, 5'h05}: f = ppfs_pkg::FN_T8B3_OUT;
            {ppfs_pkg::PIN_P55, 5'h19}: f = ppfs_pkg::FN_TOUCH_11;
            {ppfs_pkg::PIN_P55, 5'h1c}: f = ppfs_pkg::FN_CAN_RX;
            {ppfs_pkg::PIN_PA0, 5'h01}: f = ppfs_pkg::FN_MTU4_A;    // see RULE13
            {ppfs_pkg::PIN_PA0, 5'h07}: f = ppfs_pkg::FN_FREQ_REF;  // see RULE13
            {ppfs_pkg::PIN_PA0, 5'h0d}: f = ppfs_pkg::FN_SPI_SSL1;  // see RULE13
            {ppfs_pkg::PIN_PA0, 5'h19}: f = ppfs_pkg::FN_TOUCH_32;  // see RULE13
            {ppfs_pkg::PIN_PA1, 5'h01}: f = ppfs_pkg::FN_MTU0_B;
            {ppfs_pkg::PIN_PA1, 5'h02}: f = ppfs_pkg::FN_MTU_CLK_C;
            {ppfs_pkg::PIN_PA1, 5'h03}: f = ppfs_pkg::FN_MTU3_B;
            {ppfs_pkg::PIN_PA1, 5'h0a}: f = ppfs_pkg::FN_UART5_SCK;
            {ppfs_pkg::PIN_PA1, 5'h0d}: f = ppfs_pkg::FN_SPI_SSL2;
            {ppfs_pkg::PIN_PA1, 5'h19}: f = ppfs_pkg::FN_TOUCH_31;
            {ppfs_pkg::PIN_PA3, 5'h01}: f = ppfs_pkg::FN_MTU0_D;
            {ppfs_pkg::PIN_PA3, 5'h02}: f = ppfs_pkg::FN_MTU_CLK_D;
            {ppfs_pkg::PIN_PA3, 5'h03}: f = ppfs_pkg::FN_MTU4_D;
            {ppfs_pkg::PIN_PA3, 5'h04}: f = ppfs_pkg::FN_MTU5_V;
            {ppfs_pkg::PIN_PA3, 5'h0a}: f = ppfs_pkg::FN_UART5_RX;
            {ppfs_pkg::PIN_PA3, 5'h19}: f = ppfs_pkg::FN_TOUCH_29;
            {ppfs_pkg::PIN_PA4, 5'h01}: f = ppfs_pkg::FN_MTU5_U;
            {ppfs_pkg::PIN_PA4, 5'h02}: f = ppfs_pkg::FN_MTU_CLK_A;
            {ppfs_pkg::PIN_PA4, 5'h03}: f = ppfs_pkg::FN_MTU4_C;
            {ppfs_pkg::PIN_PA4, 5'h05}: f = ppfs_pkg::FN_T8B0_RST;
            {ppfs_pkg::PIN_PA4, 5'h0a}: f = ppfs_pkg::FN_UART5_TX;
            {ppfs_pkg::PIN_PA4, 5'h0d}: f = ppfs_pkg::FN_SPI_SSL0;
            {ppfs_pkg::PIN_PA4, 5'h19}: f = ppfs_pkg::FN_TOUCH_28;
            {ppfs_pkg::PIN_PA6, 5'h01}: f = ppfs_pkg::FN_MTU5_V;
            {ppfs_pkg::PIN_PA6, 5'h02}: f = ppfs_pkg::FN_MTU_CLK_B;
            {ppfs_pkg::PIN_PA6, 5'h03}: f = ppfs_pkg::FN_MTU3_D;
            {ppfs_pkg::PIN_PA6, 5'h05}: f = ppfs_pkg::FN_T8B3_CLK;
            {ppfs_pkg::PIN_PA6, 5'h07}: f = ppfs_pkg::FN_OUT_DIS_2; // see RULE15
            {ppfs_pkg::PIN_PA6, 5'h0b}: f = ppfs_pkg::FN_UART5_CTS; // see RULE15
            {ppfs_pkg::PIN_PA6, 5'h0d}: f = ppfs_pkg::FN_SPI_MOSI;  // see RULE15
            {ppfs_pkg::PIN_PA6, 5'h19}: f = ppfs_pkg::FN_TOUCH_26;  // see RULE15
            default: f = ppfs_pkg::FN_NONE;                         // see RULE1, see RULE16
        endcase
        return f;
    endfunction : route

    // Writable bits of each pin control register
    function automatic logic [7:0] wmask(input logic [3:0] pin);
        logic [7:0] m;
        m = ppfs_pkg::WMASK_SEL;
        case (pin)
            ppfs_pkg::PIN_P15, ppfs_pkg::PIN_P16, ppfs_pkg::PIN_P17,
            ppfs_pkg::PIN_P30, ppfs_pkg::PIN_P31, ppfs_pkg::PIN_P32: m = m | ppfs_pkg::WMASK_IRQ;
            ppfs_pkg::PIN_PA3, ppfs_pkg::PIN_PA4: m = m | ppfs_pkg::WMASK_IRQ | ppfs_pkg::WMASK_ANALOG;
            ppfs_pkg::PIN_PA0, ppfs_pkg::PIN_PA1, ppfs_pkg::PIN_PA6: m = m | ppfs_pkg::WMASK_ANALOG;
            default: m = ppfs_pkg::WMASK_SEL;
        endcase
        return m;
    endfunction : wmask

    // Request line of a muxed pin; only pins with a writable interrupt bit use it
    function automatic logic [2:0] irq_of(input logic [3:0] pin);
        logic [2:0] n;
        n = 3'h0;
        case (pin)
            ppfs_pkg::PIN_P15: n = 3'h5;  // see RULE7
            ppfs_pkg::PIN_P16: n = 3'h6;  // see RULE7
            ppfs_pkg::PIN_P17: n = 3'h7;  // see RULE7
            ppfs_pkg::PIN_P30: n = 3'h0;  // see RULE8
            ppfs_pkg::PIN_P31: n = 3'h1;  // see RULE8
            ppfs_pkg::PIN_P32: n = 3'h2;  // see RULE8
            ppfs_pkg::PIN_PA3: n = 3'h6;  // see RULE9
            ppfs_pkg::PIN_PA4: n = 3'h5;  // see RULE9
            default: n = 3'h0;
        endcase
        return n;
    endfunction : irq_of

    // Request line of the interrupt-only pins P12, P13, P14, P34, P36, P37
    function automatic logic [2:0] xirq_of(input int j);
        logic [2:0] n;
        n = 3'h0;
        case (j)
            0: n = 3'h2;  // see RULE7
            1: n = 3'h3;  // see RULE7
            2: n = 3'h4;  // see RULE7
            3: n = 3'h4;  // see RULE8
            4: n = 3'h2;  // see RULE8
            5: n = 3'h4;  // see RULE8
            default: n = 3'h0;
        endcase
        return n;
    endfunction : xirq_of

    // Word decode: bit 5 valid, bits 4:0 word index
    function automatic logic [5:0] decode(input logic [31:0] a);
        logic [5:0] r;
        r = {1'b0, a[6:2]};
        if (a < ppfs_pkg::OFS_LIMIT && a[1:0] == 2'h0) begin
            if (a[6:2] < 5'(ppfs_pkg::NPIN) || a == ppfs_pkg::OFS_IRQ_EXTRA || a == ppfs_pkg::OFS_ANALOG4) begin
                r[5] = 1'b1;
            end
        end
        return r;
    endfunction : decode

    always_comb begin
        logic [5:0] dec;
        logic [6:0] fn;
        logic act;
        logic [3:0] p;
        dec = 6'h00;
        fn = ppfs_pkg::FN_NONE;
        act = 1'b0;
        p = 4'h0;
        s_d = s_q;
        s_d.hreadyout = 1'b1;
        s_d.hresp = 1'b0;

        // Data phase of a write lands before any read of the same cycle
        if (s_q.wr_pend) begin
            if (s_q.wr_idx == IDX_XIRQ) begin
                s_d.xirq_sel = hwdata[ppfs_pkg::NXIRQ-1:0];
            end else if (s_q.wr_idx == IDX_AN4) begin
                s_d.an4_sel = hwdata[ppfs_pkg::NAN-1:0];
            end else begin
                s_d.pin_ctrl[s_q.wr_idx[3:0]] = hwdata[7:0] & wmask(s_q.wr_idx[3:0]);
            end
        end
        s_d.wr_pend = 1'b0;
        if (hsel && htrans[1] && hready) begin
            dec = decode(haddr);
            if (hwrite) begin
                s_d.wr_pend = dec[5];
                s_d.wr_idx = dec[4:0];
            end else begin
                s_d.hrdata = 32'h0000_0000;
                if (dec[5]) begin
                    if (dec[4:0] == IDX_XIRQ) begin
                        s_d.hrdata[ppfs_pkg::NXIRQ-1:0] = s_d.xirq_sel;
                    end else if (dec[4:0] == IDX_AN4) begin
                        s_d.hrdata[ppfs_pkg::NAN-1:0] = s_d.an4_sel;
                    end else begin
                        s_d.hrdata[7:0] = s_d.pin_ctrl[dec[3:0]];
                    end
                end
            end
        end

        // Pad synchronisers
        s_d.mux_sync1 = mux_pad_in;
        s_d.mux_sync2 = s_q.mux_sync1;
        s_d.xirq_sync1 = xirq_pad_in;
        s_d.xirq_sync2 = s_q.xirq_sync1;

        // Pin routing; analog selection takes the pin away from digital use
        s_d.pad_out = '0;
        s_d.pad_oe = '0;
        s_d.periph_in = '0;
        s_d.irq = '0;
        for (int i = 0; i < ppfs_pkg::NPIN; i++) begin
            p = 4'(i);
            fn = route(p, s_q.pin_ctrl[i][ppfs_pkg::SEL_LSB +: ppfs_pkg::SEL_W]);
            act = (fn != ppfs_pkg::FN_NONE) && !s_q.pin_ctrl[i][ppfs_pkg::ANALOG_SEL_BIT];  // see RULE1, see RULE3
            if (act) begin
                s_d.pad_oe[i] = periph_oe[fn];
                s_d.pad_out[i] = periph_out[fn] & periph_oe[fn];
                s_d.periph_in[fn] = s_d.periph_in[fn] | s_q.mux_sync2[i];
            end
            if (s_q.pin_ctrl[i][ppfs_pkg::IRQ_SEL_BIT] && !s_q.pin_ctrl[i][ppfs_pkg::ANALOG_SEL_BIT]) begin
                s_d.irq[irq_of(p)] = s_d.irq[irq_of(p)] | s_q.mux_sync2[i];  // see RULE2
            end
        end
        for (int j = 0; j < ppfs_pkg::NXIRQ; j++) begin
            if (s_q.xirq_sel[j]) begin
                s_d.irq[xirq_of(j)] = s_d.irq[xirq_of(j)] | s_q.xirq_sync2[j];  // see RULE2
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign hrdata = s_q.hrdata;
    assign hreadyout = s_q.hreadyout;
    assign hresp = s_q.hresp;
    assign mux_pad_out = s_q.pad_out;
    assign mux_pad_oe = s_q.pad_oe;
    assign periph_in = s_q.periph_in;
    assign irq_req = s_q.irq;
    assign analog_connect = s_q.an4_sel;  // see RULE3, see RULE10

endmodule : ppfs_top

// file: ppfs_monitor.sv
// Port-level assertions for the pin function multiplexer.
// Bound to ppfs_top from the testbench file; one clock domain.
`timescale 1ns/1ps
module ppfs_monitor (
    input wire logic clock, // Clock
    input wire logic rst, // Reset
    input wire logic hsel, // Select
    input wire logic [31:0] haddr, // Address
    input wire logic [1:0] htrans, // Transfer
    input wire logic hwrite, // Write
    input wire logic hready, // Bus ready
    input wire logic [31:0] hwdata, // Write data
    input wire logic [31:0] hrdata, // Read data
    input wire logic hreadyout, // Slave ready
    input wire logic hresp, // Response
    input wire logic [ppfs_pkg::NPIN-1:0] mux_pad_in, // Pad levels
    input wire logic [ppfs_pkg::NPIN-1:0] mux_pad_out, // Pad drive
    input wire logic [ppfs_pkg::NPIN-1:0] mux_pad_oe, // Pad enable
    input wire logic [ppfs_pkg::NXIRQ-1:0] xirq_pad_in, // Interrupt pads
    input wire logic [ppfs_pkg::NFN-1:0] periph_oe, // Peripheral enables
    input wire logic [ppfs_pkg::NFN-1:0] periph_in, // To peripherals
    input wire logic [ppfs_pkg::NIRQ-1:0] irq_req, // Requests
    input wire logic [ppfs_pkg::NAN-1:0] analog_connect // Analog switches
);
    logic taken, an_wr_q, rd_unm_q;
    assign taken = hsel && htrans[1] && hready;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            an_wr_q <= 1'b0;
            rd_unm_q <= 1'b0;
        end else begin
            an_wr_q <= taken && hwrite && haddr == ppfs_pkg::OFS_ANALOG4;
            rd_unm_q <= taken && !hwrite && (haddr == 32'h0000_003c || haddr >= ppfs_pkg::OFS_LIMIT);
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    chk_resp_okay: assert property (hresp == 1'b0) else $error("Error response seen");
    chk_ready_zero_wait: assert property ($past(rst) == 1'b0 |-> hreadyout) else $error("Wait state seen");
    chk_undriven_low: assert property ((mux_pad_out & ~mux_pad_oe) == '0)
        else $error("Undriven pad drives high");
    chk_oe_follows: assert property (periph_oe == '0 |=> mux_pad_oe == '0)
        else $error("Pad driven without enable");
    chk_analog_write: assert property (an_wr_q |=> {24'h0, analog_connect} == ($past(hwdata) & 32'hff))
        else $error("Analog switches wrong");
    chk_unmapped_zero: assert property (rd_unm_q |-> hrdata == 32'h0)
        else $error("Unmapped read nonzero");
    chk_rdata_hold: assert property (!(taken && !hwrite) |=> $stable(hrdata)) else $error("Read data moved");
    chk_quiet_pads: assert property ((mux_pad_in == '0 && xirq_pad_in == '0) [*3] |=> irq_req == '0 && periph_in == '0)
        else $error("Activity on quiet pads");
    cov_analog: cover property (an_wr_q);
    cov_unmapped: cover property (rd_unm_q);
    cov_irq: cover property (irq_req != '0);
endmodule : ppfs_monitor

// file: ppfs_tb.sv
// Self-checking testbench for the pin function multiplexer.
// Assumes ppfs_pkg, ppfs_top and ppfs_monitor are compiled first.
`timescale 1ns/1ps
module testbench;
    localparam logic [16:0] ROUTES [34] = '{{4'h1,5'h07,7'h0a,1'b1}, {4'h1,5'h09,7'h0b,1'b0}, {4'h1,5'h0a,7'h0c,1'b1},
        {4'h1,5'h0d,7'h0d,1'b1}, {4'h1,5'h0f,7'h0e,1'b1}, {4'h2,5'h01,7'h0f,1'b1}, {4'h2,5'h02,7'h10,1'b1},
        {4'h2,5'h05,7'h11,1'b1}, {4'h2,5'h07,7'h12,1'b0}, {4'h2,5'h0a,7'h13,1'b1}, {4'h2,5'h0d,7'h14,1'b1},
        {4'h2,5'h0f,7'h15,1'b1}, {4'h0,5'h0a,7'h04,1'b0}, {4'h0,5'h19,7'h05,1'b1}, {4'h0,5'h1c,7'h06,1'b0},
        {4'h8,5'h01,7'h1c,1'b1}, {4'h8,5'h05,7'h26,1'b0}, {4'h8,5'h19,7'h27,1'b1}, {4'h8,5'h1c,7'h28,1'b1},
        {4'h7,5'h07,7'h0a,1'b1}, {4'h7,5'h0b,7'h24,1'b1}, {4'h7,5'h19,7'h25,1'b1}, {4'ha,5'h01,7'h29,1'b1},
        {4'ha,5'h07,7'h2b,1'b0}, {4'ha,5'h0d,7'h2c,1'b1}, {4'ha,5'h19,7'h2d,1'b1}, {4'h3,5'h05,7'h11,1'b1},
        {4'h3,5'h0a,7'h0c,1'b1}, {4'h3,5'h19,7'h17,1'b1}, {4'h3,5'h1b,7'h18,1'b1}, {4'he,5'h07,7'h3e,1'b0},
        {4'he,5'h0b,7'h3f,1'b1}, {4'he,5'h0d,7'h0d,1'b1}, {4'he,5'h19,7'h40,1'b1}};
    localparam logic [6:0] IRQS [8] = '{{4'h0,3'h5}, {4'h1,3'h6}, {4'h2,3'h7}, {4'h5,3'h0}, {4'h6,3'h1}, {4'h7,3'h2},
        {4'hc,3'h6}, {4'hd,3'h5}};
    localparam logic [2:0] XIRQS [6] = '{3'h2, 3'h3, 3'h4, 3'h4, 3'h2, 3'h4};
    logic clock = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [ppfs_pkg::NPIN-1:0] mux_pad_in = '0, mux_pad_out, mux_pad_oe;
    logic [ppfs_pkg::NXIRQ-1:0] xirq_pad_in = '0;
    logic [ppfs_pkg::NFN-1:0] periph_out = '0, periph_oe = '0, periph_in;
    logic [ppfs_pkg::NIRQ-1:0] irq_req;
    logic [ppfs_pkg::NAN-1:0] analog_connect;
    int n_mismatch = 0, checks = 0, cycles = 0;
    always #5 clock = ~clock;
    ppfs_top u_dut (.hsize(3'h2), .hready(hreadyout), .*);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // One single transfer; entered and left just after a rising edge
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge clock); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] unused;
        bus(1'b1, a, d, unused);
    endtask : wr
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] v;
        bus(1'b0, a, 32'h0, v);
        check(v, exp);
    endtask : rd_chk
    task automatic t_regs();
        logic [14:0] irqm = 15'h30e7;
        logic [14:0] anm = 15'h7c00;
        for (int i = 0; i < 15; i++) begin
            rd_chk(32'(4 * i), 32'h0);
            wr(32'(4 * i), 32'hffff_ffff);
            rd_chk(32'(4 * i), {24'h0, anm[i], irqm[i], 6'h1f});
            wr(32'(4 * i), 32'h0);
        end
        rd_chk(32'h44, 32'h0);
        wr(32'h3c, 32'hffff_ffff);
        rd_chk(32'h3c, 32'h0);
        wr(32'h80, 32'hffff_ffff);
        rd_chk(32'h80, 32'h0);
    endtask : t_regs
    task automatic t_routes();
        logic [3:0] p;
        logic [4:0] c;
        logic [6:0] f;
        logic o;
        for (int k = 0; k < 34; k++) begin
            {p, c, f, o} = ROUTES[k];
            periph_oe <= {64'h0, o} << f;
            periph_out <= {64'h0, o} << f;
            mux_pad_in <= 15'h1 << p;
            wr(32'(4 * p), {27'h0, c});
            repeat (4) @(posedge clock);
            check({30'h0, mux_pad_oe[p], mux_pad_out[p]}, {30'h0, o, o});
            check({31'h0, periph_in[f]}, 32'h1);
            check({24'h0, irq_req}, 32'h0);
            wr(32'(4 * p), 32'h0);
            repeat (4) @(posedge clock);
            check({30'h0, mux_pad_oe[p], periph_in[f]}, 32'h0);
        end
    endtask : t_routes
    task automatic t_irq();
        logic [3:0] p;
        logic [2:0] q;
        for (int k = 0; k < 8; k++) begin
            {p, q} = IRQS[k];
            mux_pad_in <= 15'h1 << p;
            wr(32'(4 * p), 32'h40);
            repeat (4) @(posedge clock);
            check({24'h0, irq_req}, 32'h1 << q);
            wr(32'(4 * p), 32'h0);
            repeat (4) @(posedge clock);
            check({24'h0, irq_req}, 32'h0);
        end
        mux_pad_in <= '0;
        wr(32'h40, 32'h3f);
        for (int k = 0; k < 6; k++) begin
            xirq_pad_in <= 6'h1 << k;
            repeat (4) @(posedge clock);
            check({24'h0, irq_req}, 32'h1 << XIRQS[k]);
        end
        xirq_pad_in <= '0;
        wr(32'h40, 32'h0);
    endtask : t_irq
    task automatic t_analog();
        wr(32'h44, 32'ha5);
        @(posedge clock);
        check({24'h0, analog_connect}, 32'ha5);
        rd_chk(32'h44, 32'ha5);
        wr(32'h44, 32'h0);
        periph_oe <= {64'h0, 1'b1} << 7'h2c;
        periph_out <= {64'h0, 1'b1} << 7'h2c;
        mux_pad_in <= 15'h1 << 10;
        wr(32'h28, 32'h8d);
        repeat (4) @(posedge clock);
        check({30'h0, mux_pad_oe[10], periph_in[7'h2c]}, 32'h0);
        wr(32'h28, 32'h0d);
        repeat (4) @(posedge clock);
        check({30'h0, mux_pad_oe[10], periph_in[7'h2c]}, 32'h3);
        periph_out <= '0;
        repeat (2) @(posedge clock);
        check({30'h0, mux_pad_oe[10], mux_pad_out[10]}, 32'h2);
    endtask : t_analog
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    initial begin
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        repeat (2) @(posedge clock);
        t_regs();
        t_routes();
        t_irq();
        t_analog();
        end_of_test();
    end
endmodule : testbench
bind ppfs_top ppfs_monitor u_mon (.*);
